// File: inc/audio_mix_defs.svh
// Register offsets, field layouts, reset values and widths for the audio mixer block
`ifndef AUDIO_MIX_DEFS_SVH
`define AUDIO_MIX_DEFS_SVH

`define MUTE_MASK_OFS          8'hdc
`define MIX_GAIN_IN0_IN1_OFS   8'hdd
`define MIX_GAIN_IN2_IN3_OFS   8'hde
`define PLAYBACK_GAIN_OFS      8'hdf
`define SOURCE_SELECT_OFS      8'he0
`define THRESH_HIGH_OFS        8'he1
`define THRESH_LOW_IN01_OFS    8'he2
`define THRESH_LOW_IN23_OFS    8'he3
`define SENSE_ENABLE_OFS       8'hfc
`define SENSE_STATUS_OFS       8'hfd

`define MUTE_MASK_RST          5'h00
`define MIX_GAIN_RST           8'h00
`define PLAYBACK_GAIN_RST      4'h0
`define SOURCE_SELECT_RST      5'h14
`define THRESH_HIGH_RST        4'h0
`define THRESH_LOW_RST         8'haa
`define SENSE_ENABLE_RST       8'hff
`define SENSE_STATUS_RST       8'h00

`define GAIN_UNITY_MIN         4'h8
`define GAIN_SHIFT_MAX         4'h8
`define SEL_MASTER_PLAYBACK    5'h10
`define SEL_SLAVE_PLAYBACK     5'h12
`define SEL_SCALED_PLAYBACK    5'h14
`define SEL_EXTRA_FIRST        5'h15
`define SEL_EXTRA_LAST         5'h18
`define SAMPLE_WIDTH           10
`define LINE_COUNT             4

`endif

// File: inc/audio_mix_pkg.sv
// Types shared by the audio mixer block
package audio_mix_pkg;
	typedef logic [3:0] gain_code_t;
	typedef logic [4:0] source_code_t;
	typedef logic [4:0] presence_level_t;
endpackage : audio_mix_pkg

// File: design/audio_mix_gain_and_detect_threshold.sv
// Audio mixer gain, output source select, mute and presence detection block
// Behaviour
// - Input 2 gain low nibble, power-of-two steps.
// - Input 3 gain high nibble, same encoding.
// - Playback gain four bits, upper bits zero.
// - Selector codes 0-F pick recorded lines.
// - 10h master playback, 12h slave playback.
// - 14h scaled playback, also reset default.
// - 15h-18h pick lines 4, 9, 14, 19.
// - Unassigned selector codes give silence.
// - Threshold bit 4 gathered in one byte.
// - Threshold low nibbles packed, reset A.
// - Enable bits gate status and requests.
// - Mute mask removes sources from mix.
`include "audio_mix_defs.svh"

// Notes for whoever picks this block up next:
// Register port
//   A plain byte port that stands for the decoded two-wire bus.
//   Writes land on the rising edge with the write strobe high.
//   Read data is combinational and follows the address at once,
//   so a write shows up on the read port one cycle later.
//   Unmapped offsets ignore writes and read back zero.
//   Reserved bits are never stored, so they always read zero.
// Gain
//   Codes below eight shift right arithmetically by eight minus
//   the code; anything from eight up passes the sample unchanged.
//   Shifting keeps the multiplier out of the datapath, at the
//   cost of only power-of-two steps, which is all the codes ask.
// Mixer
//   Four line inputs and playback add in a wider accumulator.
//   The sum clips to the sample range instead of wrapping, so a
//   loud mix distorts gently rather than flipping its sign.
//   mixSum and mixOut only move on a sample strobe and hold in between.
// Source selector
//   Unassigned codes drive silence rather than a stale source.
//   The selected output and the mix sum are separate outputs.
// Presence detection
//   Audio compares the top five magnitude bits with a threshold;
//   a threshold of zero therefore reports a hit on every sample strobe.
//   The most negative sample wraps when its magnitude is taken.
//   Video pins are asynchronous and pass two flops before use,
//   then a rising edge of the synchronised level counts as a hit.
//   Status bits are sticky and cleared by writing ones; when a
//   hit and a clear meet in one cycle the hit wins, so no event
//   is lost between software reading and clearing the status.
//   Enable bits gate both the status and the event pulses.
// Limitation: the request output is a level, not a pulse.


module audio_mix_gain_and_detect_threshold
	import audio_mix_pkg::*;
#(
	parameter int W = `SAMPLE_WIDTH
) (
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	input  wire logic [7:0]            regAddr,
	input  wire logic [7:0]            regWrData,
	input  wire logic                  regWrEn,
	output logic      [7:0]            regRdData,
	input  wire logic                  sampleValid,
	input  wire logic [3:0][W-1:0]     analogAudioInput,
	input  wire logic [19:0][W-1:0]    recordedLine,
	input  wire logic [W-1:0]          playbackSample,
	input  wire logic [W-1:0]          masterPlayback,
	input  wire logic [W-1:0]          slavePlayback,
	input  wire logic [3:0]            videoPresentPin,
	output logic      [W-1:0]          mixSum,
	output logic      [W-1:0]          mixOut,
	output logic                       mixOutValid,
	output logic      [7:0]            presenceEvent,
	output logic                       presenceRequest
);

	// Register state
	logic [4:0]        muteMask_q;
	logic [3:0][3:0]   lineGain_q;
	gain_code_t        playbackGain_q;
	source_code_t      sourceSel_q;
	logic [3:0]        threshHigh_q;
	logic [3:0][3:0]   threshLow_q;
	logic [7:0]        senseEnable_q;
	logic [7:0]        senseStatus_q;
	logic [7:0]        senseStatus_d;
	logic [3:0]        videoSync1_q;
	logic [3:0]        videoSync2_q;
	logic [3:0]        videoSeen_q;
	logic [7:0]        detectHit;
	logic [W-1:0]      mixSum_d;
	logic [W-1:0]      mixOut_d;
	presence_level_t   presenceLevel [4];

	// Power-of-two attenuation: codes 0..7 give 1/256..1/2, others unity
	function automatic logic [W-1:0] apply_gain(input logic [W-1:0] s, input gain_code_t g);
		logic [W-1:0] r;
		r = s;
		if (g < `GAIN_UNITY_MIN) begin
			r = W'($signed(s) >>> (`GAIN_SHIFT_MAX - g));
		end
		return r;
	endfunction : apply_gain

	// Register write decode is shared by every register process
	function automatic logic wr_hit(input logic [7:0] ofs);
		return regWrEn && (regAddr == ofs);
	endfunction : wr_hit

	// Mute mask, writable so software can silence sources
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			muteMask_q <= `MUTE_MASK_RST;
		end else if (wr_hit(`MUTE_MASK_OFS)) begin
			muteMask_q <= regWrData[4:0];
		end
	end

	// Line gain nibbles, two per byte
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			lineGain_q <= {`MIX_GAIN_RST, `MIX_GAIN_RST};
		end else begin
			if (wr_hit(`MIX_GAIN_IN0_IN1_OFS)) begin
				lineGain_q[0] <= regWrData[3:0];
				lineGain_q[1] <= regWrData[7:4];
			end
			if (wr_hit(`MIX_GAIN_IN2_IN3_OFS)) begin
				lineGain_q[2] <= regWrData[3:0];
				lineGain_q[3] <= regWrData[7:4];
			end
		end
	end

	// Playback gain; upper nibble is not stored
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			playbackGain_q <= `PLAYBACK_GAIN_RST;
		end else if (wr_hit(`PLAYBACK_GAIN_OFS)) begin
			playbackGain_q <= regWrData[3:0];
		end
	end

	// Output source selector
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sourceSel_q <= `SOURCE_SELECT_RST;
		end else if (wr_hit(`SOURCE_SELECT_OFS)) begin
			sourceSel_q <= regWrData[4:0];
		end
	end

	// Presence thresholds: bit 4 of each gathered in one byte
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			threshHigh_q <= `THRESH_HIGH_RST;
			threshLow_q  <= {`THRESH_LOW_RST, `THRESH_LOW_RST};
		end else begin
			if (wr_hit(`THRESH_HIGH_OFS)) begin
				threshHigh_q <= regWrData[3:0];
			end
			if (wr_hit(`THRESH_LOW_IN01_OFS)) begin
				threshLow_q[0] <= regWrData[3:0];
				threshLow_q[1] <= regWrData[7:4];
			end
			if (wr_hit(`THRESH_LOW_IN23_OFS)) begin
				threshLow_q[2] <= regWrData[3:0];
				threshLow_q[3] <= regWrData[7:4];
			end
		end
	end

	// Source sense enables
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			senseEnable_q <= `SENSE_ENABLE_RST;
		end else if (wr_hit(`SENSE_ENABLE_OFS)) begin
			senseEnable_q <= regWrData;
		end
	end

	// Video presence pins come from outside, two flops before use
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			videoSync1_q <= 4'h0;
			videoSync2_q <= 4'h0;
			videoSeen_q  <= 4'h0;
		end else begin
			videoSync1_q <= videoPresentPin;
			videoSync2_q <= videoSync1_q;
			videoSeen_q  <= videoSync2_q;
		end
	end

	// Audio presence: top five magnitude bits reach the threshold
	generate
		for (genvar i = 0; i < `LINE_COUNT; i++) begin : g_detect
			logic [W-1:0] mag;
			assign presenceLevel[i] = {threshHigh_q[i], threshLow_q[i]};
			assign mag = analogAudioInput[i][W-1] ? W'(-analogAudioInput[i])
				: analogAudioInput[i];
			assign detectHit[4+i] = sampleValid && (mag[W-1 -: 5] >= presenceLevel[i]);
		end
	endgenerate
	// Video side detects on the rising edge of the synchronised level
	assign detectHit[3:0] = videoSync2_q & ~videoSeen_q;

	// Sticky status; a new detection wins over a write-one clear
	always_comb begin
		senseStatus_d = senseStatus_q;
		if (wr_hit(`SENSE_STATUS_OFS)) begin
			senseStatus_d = senseStatus_d & ~regWrData;
		end
		senseStatus_d = senseStatus_d | (detectHit & senseEnable_q);
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			senseStatus_q <= `SENSE_STATUS_RST;
			presenceEvent <= 8'h00;
		end else begin
			senseStatus_q <= senseStatus_d;
			presenceEvent <= detectHit & senseEnable_q;
		end
	end

	assign presenceRequest = |senseStatus_q;

	// Mixer sum with saturation to the sample width
	always_comb begin
		logic signed [W+2:0] acc;
		acc = '0;
		for (int i = 0; i < `LINE_COUNT; i++) begin
			if (!muteMask_q[i]) begin
				acc = acc + (W+3)'($signed(apply_gain(analogAudioInput[i], lineGain_q[i])));
			end
		end
		if (!muteMask_q[4]) begin
			acc = acc + (W+3)'($signed(apply_gain(playbackSample, playbackGain_q)));
		end
		if (acc > (W+3)'($signed({1'b0, {(W-1){1'b1}}}))) begin
			mixSum_d = {1'b0, {(W-1){1'b1}}};
		end else if (acc < (W+3)'($signed({1'b1, {(W-1){1'b0}}}))) begin
			mixSum_d = {1'b1, {(W-1){1'b0}}};
		end else begin
			mixSum_d = acc[W-1:0];
		end
	end

	// Output source selection
	always_comb begin
		mixOut_d = '0;
		if (sourceSel_q < 5'h10) begin
			// Skips every fifth recorded line: 0-3, 5-8, 10-13, 15-18
			mixOut_d = recordedLine[5'(sourceSel_q[3:2]) * 5'd5 + 5'(sourceSel_q[1:0])];
		end else if (sourceSel_q == `SEL_MASTER_PLAYBACK) begin
			mixOut_d = masterPlayback;
		end else if (sourceSel_q == `SEL_SLAVE_PLAYBACK) begin
			mixOut_d = slavePlayback;
		end else if (sourceSel_q == `SEL_SCALED_PLAYBACK) begin
			mixOut_d = apply_gain(playbackSample, playbackGain_q);
		end else if (sourceSel_q >= `SEL_EXTRA_FIRST && sourceSel_q <= `SEL_EXTRA_LAST) begin
			mixOut_d = recordedLine[5'((sourceSel_q - `SEL_EXTRA_FIRST) * 3'd5) + 5'd4];
		end
	end

	// mixSum and mixOut update once per sample period
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			mixSum      <= '0;
			mixOut      <= '0;
			mixOutValid <= 1'b0;
		end else begin
			mixOutValid <= sampleValid;
			if (sampleValid) begin
				mixSum <= mixSum_d;
				mixOut <= mixOut_d;
			end
		end
	end

	// Register read; reserved bits and unmapped offsets read zero
	always_comb begin
		case (regAddr)
			`MUTE_MASK_OFS:        regRdData = {3'h0, muteMask_q};
			`MIX_GAIN_IN0_IN1_OFS: regRdData = {lineGain_q[1], lineGain_q[0]};
			`MIX_GAIN_IN2_IN3_OFS: regRdData = {lineGain_q[3], lineGain_q[2]};
			`PLAYBACK_GAIN_OFS:    regRdData = {4'h0, playbackGain_q};
			`SOURCE_SELECT_OFS:    regRdData = {3'h0, sourceSel_q};
			`THRESH_HIGH_OFS:      regRdData = {4'h0, threshHigh_q};
			`THRESH_LOW_IN01_OFS:  regRdData = {threshLow_q[1], threshLow_q[0]};
			`THRESH_LOW_IN23_OFS:  regRdData = {threshLow_q[3], threshLow_q[2]};
			`SENSE_ENABLE_OFS:     regRdData = senseEnable_q;
			`SENSE_STATUS_OFS:     regRdData = senseStatus_q;
			default:               regRdData = 8'h00;
		endcase
	end

endmodule : audio_mix_gain_and_detect_threshold

// File: tb/audio_mix_props.sv
// Port checker for the audio mixer block
module audio_mix_props #(
	parameter int W = 10
) (
	input logic               clk_sys,
	input logic               rstn,
	input logic [7:0]         regAddr,
	input logic [7:0]         regWrData,
	input logic               regWrEn,
	input logic [7:0]         regRdData,
	input logic               sampleValid,
	input logic [19:0][W-1:0] recordedLine,
	input logic [W-1:0]       masterPlayback,
	input logic [W-1:0]       slavePlayback,
	input logic [W-1:0]       mixOut,
	input logic [W-1:0]       mixSum,
	input logic               mixOutValid,
	input logic [7:0]         presenceEvent,
	input logic               presenceRequest
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Selector only visible while the port points at it
	wire       sv = sampleValid && regAddr == 8'he0;
	wire [4:0] c  = regRdData[4:0];
	property p_vld; sampleValid |=> mixOutValid; endproperty
	a_vld: assert property (p_vld) else $error("valid pulse missing");
	property p_hold; !sampleValid |=> !mixOutValid && $stable(mixOut) && $stable(mixSum); endproperty
	a_hold: assert property (p_hold) else $error("output moved without sample");
	property p_ln; sv && c < 5'h10 |=> mixOut == $past(recordedLine[c + c[3:2]]); endproperty
	a_ln: assert property (p_ln) else $error("wrong recorded line");
	property p_pb; sv && c[4:2] == 3'b100 && !c[0] |=> mixOut == $past(c[1] ? slavePlayback : masterPlayback); endproperty
	a_pb: assert property (p_pb) else $error("wrong cascade source");
	property p_ext; sv && c inside {[5'h15:5'h18]} |=> mixOut == $past(recordedLine[5 * c - 101]); endproperty
	a_ext: assert property (p_ext) else $error("wrong extra line");
	property p_sil; sv && (c == 5'h11 || c == 5'h13 || c > 5'h18) |=> mixOut == '0; endproperty
	a_sil: assert property (p_sil) else $error("unassigned code not silent");
	property p_wr; regWrEn && regAddr == 8'he0 ##1 regAddr == 8'he0 |-> regRdData == {3'h0, $past(regWrData[4:0])}; endproperty
	a_wr: assert property (p_wr) else $error("selector readback");
	property p_rsv; regAddr inside {8'hdf, 8'he1} |-> regRdData[7:4] == 4'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved nibble set");
	property p_req; |presenceEvent |-> presenceRequest; endproperty
	a_req: assert property (p_req) else $error("event without request");
endmodule : audio_mix_props

bind audio_mix_gain_and_detect_threshold audio_mix_props #(.W(W)) u_props (.*);

// File: tb/audio_src_model.sv
// Audio sources on the far side of the mixer
module audio_src_model #(
	parameter int W = 10
) (
	input  logic               clk_sys,
	output logic [3:0][W-1:0]  analogAudioInput,
	output logic [19:0][W-1:0] recordedLine,
	output logic [W-1:0]       playbackSample,
	output logic [W-1:0]       masterPlayback,
	output logic [W-1:0]       slavePlayback
);
	timeunit 1ns;
	timeprecision 1ns;
	// Sources never idle, so fresh words land just after every edge
	initial forever begin
		foreach (analogAudioInput[i]) analogAudioInput[i] = W'($urandom);
		foreach (recordedLine[i]) recordedLine[i] = W'($urandom);
		playbackSample = W'($urandom);
		masterPlayback = W'($urandom);
		slavePlayback = W'($urandom);
		@(posedge clk_sys);
		#1;
	end
endmodule : audio_src_model

// File: tb/audio_mix_gain_and_detect_threshold_tb_top.sv
// Self-checking bench for the audio mixer with a reference model
module audio_mix_gain_and_detect_threshold_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int W = 10;
	logic               clk_sys = 0, rstn = 0, regWrEn = 0, sampleValid = 0, run = 0;
	logic [7:0]         regAddr = 8'he0, regWrData = 8'h00, regRdData, presenceEvent;
	logic [3:0]         videoPresentPin = 4'h0, ee;
	logic [3:0][W-1:0]  analogAudioInput;
	logic [19:0][W-1:0] recordedLine;
	logic [W-1:0]       playbackSample, masterPlayback, slavePlayback, mixSum, mixOut, eo, es;
	logic               mixOutValid, presenceRequest;
	logic [7:0]         rm [256];
	int                 num_errors = 0, total_checks = 0;
	audio_mix_gain_and_detect_threshold #(.W(W)) DUT (.*);
	audio_src_model #(.W(W)) u_src (.clk_sys, .analogAudioInput, .recordedLine,
		.playbackSample, .masterPlayback, .slavePlayback);
	initial forever #10 clk_sys = ~clk_sys;
	function automatic int g(logic [W-1:0] s, logic [3:0] c);
		return c < 8 ? $signed(s) >>> (8 - c) : $signed(s);
	endfunction : g
	function automatic logic [7:0] msk(logic [7:0] a);
		case (a)
			8'hdc, 8'he0: return 8'h1f;
			8'hdf, 8'he1: return 8'h0f;
			8'hdd, 8'hde, 8'he2, 8'he3, 8'hfc: return 8'hff;
			default: return 8'h00;
		endcase
	endfunction : msk
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	// Address is left in place so the next cycle reads the write back
	task automatic wr(logic [7:0] a, logic [7:0] d);
		regAddr = a;
		regWrData = d;
		regWrEn = 1;
		cyc(1);
	endtask : wr
	// Strobe stays high between back-to-back writes; dropped here
	task automatic idle(int n);
		regWrEn = 0;
		cyc(n);
	endtask : idle
	task automatic sweep;
		regWrEn = 0;
		for (int a = 8'hd8; a < 8'hff; a++) begin
			regAddr = 8'(a);
			cyc(1);
		end
	endtask : sweep
	task automatic end_sim;
		$display("Checks %0d, errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim
	// Model runs on pre-edge state; video status bits have loose latency, so masked
	always @(posedge clk_sys) begin
		automatic int s = 0;
		automatic logic [4:0] c = rm[8'he0][4:0];
		automatic logic [W-1:0] m;
		automatic logic [7:0] k;
		if (!rstn) begin
			rm = '{default: 8'h00};
			rm[8'he0] = 8'h14;
			rm[8'he2] = 8'haa;
			rm[8'he3] = 8'haa;
			rm[8'hfc] = 8'hff;
			{eo, es, ee} = '0;
		end else begin
			ee = 4'h0;
			if (sampleValid) begin
				for (int i = 0; i < 4; i++) begin
					if (!rm[8'hdc][i]) s += g(analogAudioInput[i], rm[8'hdd + i / 2] >> 4 * (i % 2));
					m = analogAudioInput[i][W-1] ? -analogAudioInput[i] : analogAudioInput[i];
					ee[i] = rm[8'hfc][4 + i] && m[W-1:W-5] >= {rm[8'he1][i], 4'(rm[8'he2 + i / 2] >> 4 * (i % 2))};
				end
				if (!rm[8'hdc][4]) s += g(playbackSample, rm[8'hdf]);
				es = W'(s > 2**(W-1) - 1 ? 2**(W-1) - 1 : s < -2**(W-1) ? -2**(W-1) : s);
				eo = c < 16 ? recordedLine[c + c / 4] : c == 16 ? masterPlayback
					: c == 18 ? slavePlayback : c == 20 ? W'(g(playbackSample, rm[8'hdf]))
					: c inside {[21:24]} ? recordedLine[5 * c - 101] : '0;
			end
			if (regWrEn && regAddr != 8'hfd) rm[regAddr] = regWrData & msk(regAddr);
			rm[8'hfd] = rm[8'hfd] & ~(regWrEn && regAddr == 8'hfd ? regWrData : 8'h00) | {ee, 4'h0};
		end
		#3;
		k = regAddr == 8'hfd ? 8'hf0 : 8'hff;
		chk(mixOut, eo);
		chk(mixSum, es);
		chk(presenceEvent[7:4], ee);
		chk(regRdData & k, rm[regAddr] & k);
	end
	// Random strobe spacing, back to back included
	always @(posedge clk_sys) begin
		#1;
		sampleValid = run & 1'($urandom);
	end
	initial begin
		void'($urandom(32'h22fb53c5));
		cyc(8);
		rstn = 1;
		sweep();
		for (int a = 8'hd8; a < 8'hff; a++) wr(8'(a), 8'($urandom));
		run = 1;
		for (int k = 0; k < 32; k++) begin
			wr(8'hdc, k < 16 || k == 20 ? 8'h00 : 8'($urandom));
			wr(8'hde, {k[3:0], 4'(15 - k)});
			wr(8'hdf, {4'($urandom), k[3:0]});
			wr(8'hdd, 8'($urandom));
			wr(8'he0, {3'($urandom), k[4:0]});
			idle(4);
		end
		for (int j = 0; j < 8; j++) begin
			wr(8'he1, j < 2 ? 8'h0c : 8'($urandom));
			wr(8'he2, j < 2 ? 8'h00 : 8'($urandom));
			wr(8'he3, j < 2 ? 8'hff : 8'($urandom));
			wr(8'hfc, 8'($urandom));
			wr(8'hfd, 8'($urandom));
			idle(3);
		end
		wr(8'hfd, 8'hff);
		videoPresentPin = 4'($urandom) | 4'h1;
		idle(8);
		chk(regRdData[3:0], videoPresentPin & rm[8'hfc][3:0]);
		rstn = 0;
		cyc(2);
		rstn = 1;
		sweep();
		end_sim();
	end
	// Whole run is near 490 cycles; twenty thousand means a hang
	initial begin
		#400us;
		num_errors++;
		end_sim();
	end
endmodule : audio_mix_gain_and_detect_threshold_tb_top
